// ---- common/etfc_pkg.sv ----
// constants for the error timestamp and fault countdown block
// assumes one node owns every record and record 0 is its first record
package etfc_pkg;
    localparam int unsigned     NUM_REC    = 2;
    localparam int unsigned     REC_W      = 1;
    localparam int unsigned     TS_W       = 64;
    localparam int unsigned     CDN_W      = 32;
    localparam int unsigned     HALF_W     = 32;
    localparam int unsigned     ADDR_W     = 12;
    localparam logic [11:0]     MISC3_OFS  = 12'h038;
    localparam logic [11:0]     CDN_OFS    = 12'h810;
    localparam logic [11:0]     REC_STRIDE = 12'h040;
    localparam logic [0:0]      FIRST_REC  = 1'h0;
    localparam logic [1:0]      FEAT_NONE  = 2'h0;
    localparam logic [63:0]     TS_RST     = 64'h0;
    localparam logic [31:0]     CDN_RST    = 32'h0;
    localparam logic [31:0]     CDN_ONE    = 32'h1;
    localparam logic [31:0]     HALF_ZERO  = 32'h0;
    // system register alias select
    localparam logic [1:0]      ALIAS_FULL = 2'h0;
    localparam logic [1:0]      ALIAS_LO   = 2'h1;
    localparam logic [1:0]      ALIAS_HI   = 2'h2;
    localparam logic [1:0]      ALIAS_CDN  = 2'h3;
    // countdown tick rate
    localparam int unsigned     CLK_PERIOD_NS  = 100;
    localparam int unsigned     TICK_PERIOD_NS = 1000;
    localparam int unsigned     TICK_CYCLES    =
        (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1
                                             : TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned     TICK_W     = 4;
    localparam logic [3:0]      TICK_LAST  = 4'(TICK_CYCLES - 1);
    localparam logic [3:0]      TICK_RST   = 4'h0;
endpackage : etfc_pkg

// ---- rtl/etfc_top.sv ----
// error timestamp registers and pseudo-fault countdown for one node
// assumes strobes and addresses synchronous to CLK_I; the pseudo-fault
// control register is decoded outside this block and its writes arrive on the CTL_ port
module etfc_top
    import etfc_pkg::*;
(
    // clock and cold reset
    input  wire logic                  CLK_I,
    input  wire logic                  RESET_N_I,
    // memory-mapped access
    input  wire logic                  MM_WR_I,
    input  wire logic                  MM_RD_I,
    input  wire logic [ADDR_W-1:0]     MM_ADDR_I,
    input  wire logic [TS_W-1:0]       MM_WDATA_I,
    output logic      [TS_W-1:0]       MM_RDATA_O,
    // system register access
    input  wire logic                  SR_WR_I,
    input  wire logic                  SR_RD_I,
    input  wire logic [REC_W-1:0]      SR_RECORD_INDEX_SELECTOR_I,
    input  wire logic [1:0]            SR_ALIAS_I,
    input  wire logic [TS_W-1:0]       SR_WDATA_I,
    output logic      [TS_W-1:0]       SR_RDATA_O,
    // pseudo-fault control write port
    input  wire logic                  CTL_WR_I,
    input  wire logic                  CTL_COUNTDOWN_ENABLE_I,
    input  wire logic                  CTL_RESTART_I,
    output logic                       COUNTDOWN_ENABLE_O,
    output logic                       RESTART_O,
    // record status and features
    input  wire logic [NUM_REC-1:0]    ERR_DETECT_I,
    input  wire logic [NUM_REC-1:0]    MISC_SYNDROME_VALID_I,
    input  wire logic [TS_W-1:0]       TIMESTAMP_I,
    input  wire logic [1:0]            TIMESTAMP_FEATURE_FIELD_I,
    input  wire logic [1:0]            INJECTION_FEATURE_FIELD_I,
    // injection request
    output logic                       INJECT_O
);

    logic [NUM_REC-1:0][TS_W-1:0] ts_all;
    logic [CDN_W-1:0]             cdn_q;
    logic [CDN_W-1:0]             gen_cnt_q;
    logic [TICK_W-1:0]            tick_cnt_q;
    logic                         tick;
    logic                         countdown_enable_q;
    logic                         restart_q;
    logic                         inject_q;
    logic                         cdn_present;
    logic                         ts_feat;
    logic                         mm_cdn_hit;
    logic                         sr_cdn_hit;
    logic                         ctl_load;
    logic                         dec;
    logic [TS_W-1:0]              mm_rdata_d;
    logic [TS_W-1:0]              sr_rdata_d;
    logic [TS_W-1:0]              mm_rdata_q;
    logic [TS_W-1:0]              sr_rdata_q;

    function automatic logic [ADDR_W-1:0] ts_addr(input int unsigned idx);
        ts_addr = MISC3_OFS + 12'(idx) * REC_STRIDE;
    endfunction : ts_addr

    assign cdn_present = INJECTION_FEATURE_FIELD_I != FEAT_NONE;
    assign ts_feat     = TIMESTAMP_FEATURE_FIELD_I != FEAT_NONE;
    assign mm_cdn_hit  = cdn_present && MM_ADDR_I == CDN_OFS;
    assign sr_cdn_hit  = cdn_present && SR_ALIAS_I == ALIAS_CDN
                      && SR_RECORD_INDEX_SELECTOR_I == FIRST_REC;

    // ------------------------------------------------------------------
    // timestamp records
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_REC; i++) begin : g_rec
        logic [TS_W-1:0] ts_q;
        logic [TS_W-1:0] wr_val;
        logic            wr_en;
        logic            sr_hit;

        assign sr_hit = SR_RECORD_INDEX_SELECTOR_I == REC_W'(i);

        always_comb begin
            wr_en  = 1'b0;
            wr_val = ts_q;
            if (MM_WR_I && MM_ADDR_I == ts_addr(i)) begin
                wr_en  = 1'b1;
                wr_val = MM_WDATA_I;
            end else if (SR_WR_I && sr_hit) begin
                unique case (SR_ALIAS_I)
                    ALIAS_FULL: begin
                        wr_en  = 1'b1;
                        wr_val = SR_WDATA_I;
                    end
                    ALIAS_LO: begin
                        wr_en  = 1'b1;
                        wr_val = {ts_q[TS_W-1:HALF_W],
                                  SR_WDATA_I[HALF_W-1:0]};
                    end
                    ALIAS_HI: begin
                        wr_en  = 1'b1;
                        wr_val = {SR_WDATA_I[HALF_W-1:0],
                                  ts_q[HALF_W-1:0]};
                    end
                    ALIAS_CDN: begin
                        wr_en  = 1'b0;
                    end
                endcase
            end
        end

        // cold reset loads TS_RST (zero); error recovery reset leaves it
        always_ff @(posedge CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                ts_q <= TS_RST;
            end else if (ERR_DETECT_I[i] && ts_feat) begin
                ts_q <= TIMESTAMP_I;
            end else if (wr_en && !MISC_SYNDROME_VALID_I[i]) begin
                // plain storage: zero is quiescent, no interrupt source
                ts_q <= wr_val;
            end
        end

        assign ts_all[i] = ts_q;
    end : g_rec

    // ------------------------------------------------------------------
    // read paths
    // ------------------------------------------------------------------
    // the live counter never appears on either read mux
    always_comb begin
        mm_rdata_d = '0;
        for (int unsigned k = 0; k < NUM_REC; k++) begin
            if (MM_ADDR_I == ts_addr(k)) begin
                mm_rdata_d = ts_all[k];
            end
        end
        if (mm_cdn_hit) begin
            mm_rdata_d = {HALF_ZERO, cdn_q};
        end
    end

    always_comb begin
        sr_rdata_d = '0;
        unique case (SR_ALIAS_I)
            ALIAS_FULL: sr_rdata_d = ts_all[SR_RECORD_INDEX_SELECTOR_I];
            ALIAS_LO:   sr_rdata_d = {HALF_ZERO,
                ts_all[SR_RECORD_INDEX_SELECTOR_I][HALF_W-1:0]};
            ALIAS_HI:   sr_rdata_d = {HALF_ZERO,
                ts_all[SR_RECORD_INDEX_SELECTOR_I][TS_W-1:HALF_W]};
            ALIAS_CDN: begin
                if (sr_cdn_hit) begin
                    sr_rdata_d = {HALF_ZERO, cdn_q};
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mm_rdata_q <= '0;
        end else if (MM_RD_I) begin
            mm_rdata_q <= mm_rdata_d;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sr_rdata_q <= '0;
        end else if (SR_RD_I) begin
            sr_rdata_q <= sr_rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // countdown reload register
    // ------------------------------------------------------------------
    // memory path wins over a same-cycle system write
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cdn_q <= CDN_RST;
        end else if (MM_WR_I && mm_cdn_hit) begin
            cdn_q <= MM_WDATA_I[CDN_W-1:0];
        end else if (SR_WR_I && sr_cdn_hit) begin
            cdn_q <= SR_WDATA_I[CDN_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // pseudo-fault control bits
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            countdown_enable_q   <= 1'b0;
            restart_q <= 1'b0;
        end else if (CTL_WR_I) begin
            countdown_enable_q   <= CTL_COUNTDOWN_ENABLE_I;
            restart_q <= CTL_RESTART_I;
        end
    end

    // ------------------------------------------------------------------
    // tick divider
    // ------------------------------------------------------------------
    assign tick = tick_cnt_q == TICK_LAST;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tick_cnt_q <= TICK_RST;
        end else if (tick) begin
            tick_cnt_q <= TICK_RST;
        end else begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // error generation counter
    // ------------------------------------------------------------------
    assign ctl_load = CTL_WR_I && CTL_COUNTDOWN_ENABLE_I && cdn_present;
    assign dec      = countdown_enable_q && tick && cdn_present
                   && gen_cnt_q != CDN_RST;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gen_cnt_q <= CDN_RST;
        end else if (ctl_load) begin
            gen_cnt_q <= cdn_q;
        end else if (dec) begin
            if (gen_cnt_q == CDN_ONE) begin
                gen_cnt_q <= restart_q ? cdn_q : CDN_RST;
            end else begin
                gen_cnt_q <= gen_cnt_q - CDN_ONE;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            inject_q <= 1'b0;
        end else begin
            // a same-cycle reload means zero was never reached
            inject_q <= dec && gen_cnt_q == CDN_ONE && !ctl_load;
        end
    end

    assign MM_RDATA_O         = mm_rdata_q;
    assign SR_RDATA_O         = sr_rdata_q;
    assign COUNTDOWN_ENABLE_O = countdown_enable_q;
    assign RESTART_O          = restart_q;
    assign INJECT_O           = inject_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_last_tick;
        dec && gen_cnt_q == CDN_ONE && !ctl_load;
    endsequence

    sequence s_ctl_enable;
        CTL_WR_I && CTL_COUNTDOWN_ENABLE_I && cdn_present;
    endsequence

    AST_INJ_ONCE: assert property (
        s_last_tick |=> INJECT_O ##1 !INJECT_O)
        else $error("injection pulse not exactly one cycle");

    AST_LOAD: assert property (
        s_ctl_enable |=> gen_cnt_q == $past(cdn_q))
        else $error("counter not loaded on enable write");

    AST_RESTART: assert property (
        s_last_tick and restart_q |=> gen_cnt_q == $past(cdn_q))
        else $error("counter not reloaded on restart");

    AST_STOP: assert property (
        s_last_tick and !restart_q |=> gen_cnt_q == CDN_RST
            ##1 (gen_cnt_q == CDN_RST || $past(ctl_load)))
        else $error("counter did not stop at zero");

    AST_DECREMENT: assert property (
        dec && gen_cnt_q != CDN_ONE && !ctl_load
            |=> gen_cnt_q == $past(gen_cnt_q) - CDN_ONE)
        else $error("counter did not decrement by one");

    AST_DISABLED: assert property (
        !countdown_enable_q && !CTL_WR_I |=> $stable(gen_cnt_q) && !INJECT_O)
        else $error("disabled counter moved");

    AST_TICK_RATE: assert property (
        tick |=> !tick [*1] ##0 (tick_cnt_q == TICK_RST))
        else $error("tick divider not restarted");

    AST_TS_CAPTURE: assert property (
        ERR_DETECT_I[0] && ts_feat |=> ts_all[0] == $past(TIMESTAMP_I))
        else $error("timestamp not captured on detection");

    AST_TS_LOCK: assert property (
        MISC_SYNDROME_VALID_I[0] && !ERR_DETECT_I[0]
            |=> $stable(ts_all[0]))
        else $error("timestamp changed while misc-valid set");

    AST_CDN_UPPER: assert property (
        MM_RD_I && mm_cdn_hit |=> MM_RDATA_O[TS_W-1:HALF_W] == HALF_ZERO)
        else $error("countdown upper bits not zero");

    AST_CDN_ABSENT: assert property (
        MM_RD_I && MM_ADDR_I == CDN_OFS + REC_STRIDE |=> MM_RDATA_O == '0)
        else $error("countdown of later record not zero");

    AST_ENABLE_RST: assert property (
        !CTL_WR_I |=> $stable(countdown_enable_q))
        else $error("countdown enable changed without write");

endmodule : etfc_top

// ---- testbench/testbench.sv ----
// self-checking bench for the error timestamp and fault countdown block
// assumes etfc_pkg compiled first; drives all ports directly, no partner
module testbench
    import etfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        mm_wr = 1'b0, mm_rd = 1'b0, sr_wr = 1'b0, sr_rd = 1'b0;
    logic [11:0] mm_addr = 12'h000;
    logic [63:0] mm_wdata = 64'h0, sr_wdata = 64'h0, timestamp = 64'h0;
    logic [63:0] mm_rdata, sr_rdata;
    logic [0:0]  sr_sel = 1'h0;
    logic [1:0]  sr_alias = 2'h0, ts_feat = 2'h1, inj_feat = 2'h1;
    logic        ctl_wr = 1'b0, ctl_en = 1'b0, ctl_rs = 1'b0;
    logic [1:0]  err_detect = 2'h0, misc_valid = 2'h0;
    logic        cdn_en, restart, inject;
    logic [31:0] lfsr_q = 32'h01BAB4B0;
    int          fail_count = 0;
    int          check_count = 0;
    always #50 clk = ~clk;
    etfc_top etfc_top_inst (
        .CLK_I(clk), .RESET_N_I(reset_n), .MM_WR_I(mm_wr), .MM_RD_I(mm_rd),
        .MM_ADDR_I(mm_addr), .MM_WDATA_I(mm_wdata), .MM_RDATA_O(mm_rdata),
        .SR_WR_I(sr_wr), .SR_RD_I(sr_rd),
        .SR_RECORD_INDEX_SELECTOR_I(sr_sel), .SR_ALIAS_I(sr_alias),
        .SR_WDATA_I(sr_wdata), .SR_RDATA_O(sr_rdata), .CTL_WR_I(ctl_wr),
        .CTL_COUNTDOWN_ENABLE_I(ctl_en), .CTL_RESTART_I(ctl_rs),
        .COUNTDOWN_ENABLE_O(cdn_en), .RESTART_O(restart),
        .ERR_DETECT_I(err_detect), .MISC_SYNDROME_VALID_I(misc_valid),
        .TIMESTAMP_I(timestamp), .TIMESTAMP_FEATURE_FIELD_I(ts_feat),
        .INJECTION_FEATURE_FIELD_I(inj_feat), .INJECT_O(inject));
    // ------------------------------------------------------------
    // helpers and expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic rnd64(output logic [63:0] v);
        repeat (32) lfsr_q = lfsr_next(lfsr_q);
        v[31:0] = lfsr_q;
        repeat (32) lfsr_q = lfsr_next(lfsr_q);
        v[63:32] = lfsr_q;
    endtask : rnd64
    function automatic logic [11:0] ts_addr(input int rec);
        return 12'h038 + 12'(rec * 64);
    endfunction : ts_addr
    function automatic logic [63:0] merge_half(input logic [63:0] old,
                                               input logic [1:0] al,
                                               input logic [63:0] d);
        if (al == 2'h1) return {old[63:32], d[31:0]};
        return {d[31:0], old[31:0]};
    endfunction : merge_half
    function automatic logic [63:0] half_of(input logic [63:0] v,
                                            input logic [1:0] al);
        return (al == 2'h1) ? {32'h0, v[31:0]} : {32'h0, v[63:32]};
    endfunction : half_of
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic mm_access(input logic w, input logic [11:0] a,
                             input logic [63:0] d, output logic [63:0] q);
        @(posedge clk);
        #10;
        mm_addr = a;
        mm_wdata = d;
        mm_wr = w;
        mm_rd = !w;
        @(posedge clk);
        #10;
        mm_wr = 1'b0;
        mm_rd = 1'b0;
        @(posedge clk);
        #10;
        q = mm_rdata;
    endtask : mm_access
    task automatic sr_access(input logic w, input logic [0:0] sel,
                             input logic [1:0] al, input logic [63:0] d,
                             output logic [63:0] q);
        @(posedge clk);
        #10;
        sr_sel = sel;
        sr_alias = al;
        sr_wdata = d;
        sr_wr = w;
        sr_rd = !w;
        @(posedge clk);
        #10;
        sr_wr = 1'b0;
        sr_rd = 1'b0;
        @(posedge clk);
        #10;
        q = sr_rdata;
    endtask : sr_access
    task automatic ctl_write(input logic en, input logic rs);
        @(posedge clk);
        #10;
        ctl_en = en;
        ctl_rs = rs;
        ctl_wr = 1'b1;
        @(posedge clk);
        #10;
        ctl_wr = 1'b0;
    endtask : ctl_write
    task automatic wait_inj(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #10;
            n++;
        end while (inject !== 1'b1 && n < lim);
    endtask : wait_inj
    task automatic count_inj(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge clk);
            #10;
            if (inject === 1'b1) c++;
        end
    endtask : count_inj
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #2000000;
        fail_count++;
        end_of_test();
    end
    initial begin : main
        logic [63:0] d, q, m, ts;
        int n;
        repeat (20) @(posedge clk);
        #10 reset_n = 1'b1;
        // reset state
        check(64'(cdn_en), 64'h0);
        mm_access(1'b0, 12'h038, 64'h0, q);
        check(q, TS_RST);
        mm_access(1'b0, 12'h810, 64'h0, q);
        check(q, 64'(CDN_RST));
        $display("test reset done");
        // timestamp through both paths, all aliases
        for (int rec = 0; rec < 2; rec++) begin
            rnd64(d);
            mm_access(1'b1, ts_addr(rec), d, q);
            mm_access(1'b0, ts_addr(rec), 64'h0, q);
            check(q, d);
            sr_access(1'b0, 1'(rec), 2'h0, 64'h0, q);
            check(q, d);
            m = d;
            for (int al = 1; al < 3; al++) begin
                rnd64(d);
                sr_access(1'b1, 1'(rec), 2'(al), d, q);
                m = merge_half(m, 2'(al), d);
                sr_access(1'b0, 1'(rec), 2'(al), 64'h0, q);
                check(q, half_of(m, 2'(al)));
            end
            mm_access(1'b0, ts_addr(rec), 64'h0, q);
            check(q, m);
            // misc-valid lock, then release
            misc_valid[rec] = 1'b1;
            rnd64(d);
            mm_access(1'b1, ts_addr(rec), d, q);
            sr_access(1'b1, 1'(rec), 2'h1, d, q);
            mm_access(1'b0, ts_addr(rec), 64'h0, q);
            check(q, m);
            misc_valid[rec] = 1'b0;
            mm_access(1'b1, ts_addr(rec), d, q);
            mm_access(1'b0, ts_addr(rec), 64'h0, q);
            check(q, d);
            // capture on detection, with and without the feature
            for (int f = 0; f < 2; f++) begin
                @(posedge clk);
                #10;
                ts_feat = f ? 2'h2 : 2'h0;
                rnd64(ts);
                timestamp = ts;
                err_detect[rec] = 1'b1;
                @(posedge clk);
                #10;
                err_detect = 2'h0;
                mm_access(1'b0, ts_addr(rec), 64'h0, q);
                check(q, f ? ts : d);
                d = q;
            end
        end
        $display("test timestamp done");
        // countdown register map
        rnd64(d);
        mm_access(1'b1, 12'h810, d, q);
        mm_access(1'b0, 12'h810, 64'h0, q);
        check(q, {32'h0, d[31:0]});
        rnd64(d);
        sr_access(1'b1, 1'h0, 2'h3, d, q);
        mm_access(1'b0, 12'h810, 64'h0, q);
        check(q, {32'h0, d[31:0]});
        mm_access(1'b1, 12'h850, d, q);
        mm_access(1'b0, 12'h850, 64'h0, q);
        check(q, 64'h0);
        sr_access(1'b1, 1'h1, 2'h3, d, q);
        sr_access(1'b0, 1'h1, 2'h3, 64'h0, q);
        check(q, 64'h0);
        mm_access(1'b0, 12'h100, 64'h0, q);
        check(q, 64'h0);
        inj_feat = 2'h0;
        mm_access(1'b0, 12'h810, 64'h0, q);
        check(q, 64'h0);
        inj_feat = 2'h3;
        $display("test countdown map done");
        // one-shot countdown
        mm_access(1'b1, 12'h810, {32'hFFFF_FFFF, 32'h2}, q);
        ctl_write(1'b1, 1'b0);
        check(64'(cdn_en), 64'h1);
        wait_inj(4 * TICK_CYCLES, n);
        check(64'(n >= TICK_CYCLES && n <= 2 * TICK_CYCLES + 1), 64'h1);
        count_inj(6 * TICK_CYCLES, n);
        check(64'(n), 64'h0);
        // restart gives a fixed period of reload ticks
        ctl_write(1'b1, 1'b1);
        check(64'(restart), 64'h1);
        wait_inj(4 * TICK_CYCLES, n);
        check(64'(inject), 64'h1);
        wait_inj(4 * TICK_CYCLES, n);
        check(64'(n), 64'(2 * TICK_CYCLES));
        // disable freezes, zero reload never fires
        ctl_write(1'b0, 1'b1);
        count_inj(6 * TICK_CYCLES, n);
        check(64'(n), 64'h0);
        mm_access(1'b1, 12'h810, 64'h0, q);
        ctl_write(1'b1, 1'b0);
        count_inj(6 * TICK_CYCLES, n);
        check(64'(n), 64'h0);
        $display("test countdown run done");
        // cold reset in mid-run clears a set countdown enable
        ctl_write(1'b1, 1'b1);
        check(64'(cdn_en), 64'h1);
        @(posedge clk);
        #10;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #10;
        reset_n = 1'b1;
        check(64'(cdn_en), 64'h0);
        $display("test cold reset done");
        end_of_test();
    end : main
endmodule : testbench
